// file: rtl/secproto_pkg.sv
/*
 * Shared constants for the security transfer command decoder: descriptor
 * layout, opcodes, protocol selector ranges, status and sense codes.
 * Assumes a byte-wide command/data path driven by the command engine.
 */
package secproto_pkg;
	localparam int CDB_LEN = 12;
	localparam logic [7:0] OP_SEC_IN = 8'hA2;
	localparam logic [7:0] OP_SEC_OUT = 8'hB5;
	localparam logic [7:0] PROT_INFO = 8'h00;
	localparam logic [7:0] PROT_FIRST = 8'h01;
	localparam logic [7:0] PROT_LAST = 8'h06;
	localparam int BYTE_OPCODE = 0;
	localparam int BYTE_PROT = 1;
	localparam int BYTE_SPEC_HI = 2;
	localparam int BYTE_SPEC_LO = 3;
	localparam int BYTE_UNIT = 4;
	localparam int BIT_INC512 = 7;
	localparam int BYTE_LEN0 = 6;
	localparam int BLOCK_SHIFT = 9;
	localparam logic [7:0] PAD_BYTE = 8'h00;
	localparam logic [7:0] STAT_GOOD = 8'h00;
	localparam logic [7:0] STAT_CHECK = 8'h02;
	localparam logic [3:0] SK_ILLEGAL = 4'h5;
	localparam logic [7:0] ASC_INV_CDB = 8'h24;
	localparam logic [7:0] ASCQ_NONE = 8'h00;
	localparam logic [7:0] NO_DATA_BYTE = 8'h00;
	localparam int LEN_W = 41;
endpackage

// file: rtl/secproto_cdb_parse.sv
/*
 * Collects the 12 descriptor bytes and decodes the fields.
 * Assumes cdb_valid strobes bytes in order starting with byte 0.
 */
`timescale 1ns/1ps
`default_nettype none
module secproto_cdb_parse
	import secproto_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic rst, // Async reset
	input wire logic cdb_valid, // Descriptor byte strobe
	input wire logic [7:0] cdb_byte, // Descriptor byte
	output logic cdb_done, // Pulse: all bytes held
	output logic [7:0] opcode, // Byte 0
	output logic [7:0] prot, // Byte 1
	output logic [15:0] spec, // Bytes 2-3
	output logic inc512, // Length unit bit
	output logic [31:0] len_raw // Bytes 6-9
);
	logic [7:0] cdb_q [CDB_LEN];
	logic [3:0] idx_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			idx_q <= 4'h0;
			cdb_done <= 1'b0;
		end
		else
		begin
			cdb_done <= 1'b0;
			if (cdb_valid)
			begin
				if (idx_q == 4'(CDB_LEN - 1))
				begin
					idx_q <= 4'h0;
					cdb_done <= 1'b1;
				end
				else
					idx_q <= idx_q + 4'h1;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (cdb_valid)
			cdb_q[idx_q] <= cdb_byte;
	end

	assign opcode = cdb_q[BYTE_OPCODE];
	assign prot = cdb_q[BYTE_PROT];
	assign spec = {cdb_q[BYTE_SPEC_HI], cdb_q[BYTE_SPEC_LO]};
	assign inc512 = cdb_q[BYTE_UNIT][BIT_INC512];
	assign len_raw = {cdb_q[BYTE_LEN0], cdb_q[BYTE_LEN0 + 1], cdb_q[BYTE_LEN0 + 2], cdb_q[BYTE_LEN0 + 3]};
endmodule
`default_nettype wire

// file: rtl/secproto_result_buf.sv
/*
 * Holds result bytes produced by delivery-command processing.
 * Assumes one writer and one reader; contents dropped on clear.
 */
`timescale 1ns/1ps
`default_nettype none
module secproto_result_buf #(
	parameter int DEPTH = 256
) (
	input wire logic clk, // Clock
	input wire logic rst, // Async reset
	input wire logic clear, // Discard held results
	input wire logic wr_en, // Write a result byte
	input wire logic [7:0] wr_data, // Result byte
	input wire logic rd_en, // Consume one byte
	output logic [7:0] rd_data, // Byte at read pointer
	output logic [$clog2(DEPTH):0] count // Bytes held
);
	localparam int AW = $clog2(DEPTH);
	logic [7:0] mem [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic do_wr;
	logic do_rd;

	assign do_wr = wr_en && (cnt_q != (AW+1)'(DEPTH));
	assign do_rd = rd_en && (cnt_q != '0);
	assign count = cnt_q;
	assign rd_data = mem[rp_q];

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end
		else if (clear)
		begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (do_wr)
				wp_q <= wp_q + AW'(1);
			if (do_rd)
				rp_q <= rp_q + AW'(1);
			cnt_q <= cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end

	always_ff @(posedge clk)
	begin
		if (do_wr)
			mem[wp_q] <= wr_data;
	end
endmodule
`default_nettype wire

// file: rtl/secproto_cmd_decoder.sv
/*
 * Security transfer command decoder: parses the descriptor, runs the
 * return (in) and delivery (out) data phases, ends with status and sense.
 * Assumes the command engine supplies descriptor bytes, moves data bytes
 * with valid/ready, and runs the protocol engine beside this block.
 */
// Summary of operation
// - Opcode A2h is the return command, sending protocol info or held results to the host.
// - Opcode B5h is the delivery command, whose parameter list goes to the protocol engine.
// - Return selector 00h is protocol info, 01h-06h are protocols, 07h-FFh reserved.
// - Delivery selector 00h and 07h-FFh are reserved, 01h-06h are protocols.
// - Bytes 2-3 pass unchanged to the protocol engine, meaning fixed by the selector.
// - With the unit bit set, the return allocation length counts 512-byte blocks.
// - With the unit bit clear, the return allocation length is a byte maximum.
// - Return data may be padded to the scaled length, and pad bytes are 00h.
// - With the unit bit clear on delivery, exactly the transfer length in bytes is received.
// - With no result pending, a return sends a nothing-to-transfer reply.
// - Delivery results stay held until read on the same path, unit reset or connection loss.
// - First-style protocols report GOOD once the data is received; the host then reads results.
// - Second-style protocols report GOOD only after the engine reports success.
`timescale 1ns/1ps
`default_nettype none
module secproto_cmd_decoder
	import secproto_pkg::*;
#(
	parameter int RES_DEPTH = 256,
	parameter int NEXUS_W = 8
) (
	input wire logic clk, // Clock
	input wire logic rst, // Async reset
	input wire logic cdb_valid, // Descriptor byte strobe
	input wire logic [7:0] cdb_byte, // Descriptor byte
	input wire logic [NEXUS_W-1:0] cmd_nexus, // Issuing path of the command
	input wire logic lu_reset, // Logical unit reset pulse
	input wire logic nexus_loss, // Connection loss pulse
	input wire logic [NEXUS_W-1:0] loss_nexus, // Path that was lost
	input wire logic [7:0] dout_data, // Host to device byte
	input wire logic dout_valid, // Host byte valid
	output logic dout_ready, // Device takes host byte
	output logic [7:0] din_data, // Device to host byte
	output logic din_valid, // Device byte valid
	input wire logic din_ready, // Host takes device byte
	output logic [7:0] eng_prot, // Selector to protocol engine
	output logic [15:0] eng_spec, // Protocol-specific bytes
	output logic eng_start, // Pulse: command accepted
	output logic [7:0] eng_data, // Delivered byte to engine
	output logic eng_data_valid, // Delivered byte strobe
	input wire logic eng_style_b, // Protocol waits for processing
	input wire logic eng_done, // Processing finished
	input wire logic eng_ok, // Processing succeeded
	input wire logic [7:0] info_data, // Protocol info byte
	input wire logic info_valid, // Protocol info byte available
	output logic info_ready, // Info byte taken
	input wire logic [7:0] res_data, // Result byte from engine
	input wire logic res_valid, // Result byte strobe
	output logic done, // Pulse: command complete
	output logic [7:0] status, // Completion status
	output logic [3:0] sense_key, // Sense key
	output logic [7:0] sense_asc, // Additional sense code
	output logic [7:0] sense_ascq // Additional sense qualifier
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DECODE = 3'b001,
		ST_IN = 3'b011,
		ST_OUT = 3'b010,
		ST_WAIT = 3'b110,
		ST_STATUS = 3'b111
	} state_e;

	state_e state_q;
	logic cdb_done;
	logic [7:0] opcode;
	logic [7:0] prot;
	logic [15:0] spec;
	logic inc512;
	logic [31:0] len_raw;
	logic [LEN_W-1:0] len_q;
	logic [LEN_W-1:0] sent_q;
	logic [LEN_W-1:0] scaled;
	logic is_in_q;
	logic no_data_q;
	logic from_info_q;
	logic [7:0] status_q;
	logic bad_q;
	logic [NEXUS_W-1:0] owner_q;
	logic [NEXUS_W-1:0] cur_q;
	logic buf_clear;
	logic buf_rd;
	logic [7:0] buf_data;
	logic [$clog2(RES_DEPTH):0] buf_count;
	logic in_beat;
	logic out_beat;
	logic real_byte;

	function automatic logic prot_reserved(input logic [7:0] op, input logic [7:0] p);
		logic in_range;
		in_range = (p >= PROT_FIRST) && (p <= PROT_LAST);
		if (op == OP_SEC_IN)
			prot_reserved = !(in_range || p == PROT_INFO);
		else
			prot_reserved = !in_range;
	endfunction

	secproto_cdb_parse u_parse (
		.clk(clk),
		.rst(rst),
		.cdb_valid(cdb_valid),
		.cdb_byte(cdb_byte),
		.cdb_done(cdb_done),
		.opcode(opcode),
		.prot(prot),
		.spec(spec),
		.inc512(inc512),
		.len_raw(len_raw)
	);

	// Held results survive until read on the owning path or dropped
	assign buf_clear = lu_reset || (nexus_loss && loss_nexus == owner_q);

	secproto_result_buf #(
		.DEPTH(RES_DEPTH)
	) u_res (
		.clk(clk),
		.rst(rst),
		.clear(buf_clear),
		.wr_en(res_valid),
		.wr_data(res_data),
		.rd_en(buf_rd),
		.rd_data(buf_data),
		.count(buf_count)
	);

	assign scaled = inc512 ? (LEN_W'(len_raw) << BLOCK_SHIFT) : LEN_W'(len_raw);

	// Data real until source runs dry, then pad
	always_comb
	begin
		real_byte = 1'b0;
		if (no_data_q)
			real_byte = 1'b1;
		else if (from_info_q)
			real_byte = info_valid;
		else
			real_byte = (buf_count != '0);
	end

	assign din_valid = (state_q == ST_IN) && (sent_q != len_q);
	assign in_beat = din_valid && din_ready;
	assign info_ready = in_beat && from_info_q && info_valid;
	assign buf_rd = in_beat && !from_info_q && !no_data_q && (buf_count != '0);
	assign dout_ready = (state_q == ST_OUT) && (sent_q != len_q);
	assign out_beat = dout_ready && dout_valid;

	always_comb
	begin
		if (no_data_q)
			din_data = NO_DATA_BYTE;
		else if (!real_byte)
			din_data = PAD_BYTE;
		else if (from_info_q)
			din_data = info_data;
		else
			din_data = buf_data;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			eng_data <= 8'h00;
			eng_data_valid <= 1'b0;
		end
		else
		begin
			eng_data_valid <= out_beat;
			if (out_beat)
				eng_data <= dout_data;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			owner_q <= '0;
		else if (state_q == ST_OUT && sent_q == len_q)
			owner_q <= cur_q;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_q <= ST_IDLE;
			len_q <= '0;
			sent_q <= '0;
			is_in_q <= 1'b0;
			no_data_q <= 1'b0;
			from_info_q <= 1'b0;
			bad_q <= 1'b0;
			status_q <= STAT_GOOD;
			cur_q <= '0;
			eng_prot <= 8'h00;
			eng_spec <= 16'h0000;
			eng_start <= 1'b0;
		end
		else
		begin
			eng_start <= 1'b0;
			case (state_q)
				ST_IDLE:
				begin
					if (cdb_done)
					begin
						cur_q <= cmd_nexus;
						state_q <= ST_DECODE;
					end
				end
				ST_DECODE:
				begin
					sent_q <= '0;
					len_q <= scaled;
					is_in_q <= (opcode == OP_SEC_IN);
					from_info_q <= (prot == PROT_INFO);
					no_data_q <= (prot != PROT_INFO) && (buf_count == '0 || owner_q != cur_q);
					if ((opcode != OP_SEC_IN && opcode != OP_SEC_OUT) || prot_reserved(opcode, prot))
					begin
						bad_q <= 1'b1;
						status_q <= STAT_CHECK;
						state_q <= ST_STATUS;
					end
					else
					begin
						bad_q <= 1'b0;
						status_q <= STAT_GOOD;
						eng_prot <= prot;
						eng_spec <= spec;
						eng_start <= 1'b1;
						state_q <= (opcode == OP_SEC_IN) ? ST_IN : ST_OUT;
					end
				end
				ST_IN:
				begin
					if (in_beat)
						sent_q <= sent_q + LEN_W'(1);
					if (sent_q == len_q)
						state_q <= ST_STATUS;
				end
				ST_OUT:
				begin
					if (out_beat)
						sent_q <= sent_q + LEN_W'(1);
					if (sent_q == len_q)
						state_q <= eng_style_b ? ST_WAIT : ST_STATUS;
				end
				ST_WAIT:
				begin
					if (eng_done)
					begin
						status_q <= eng_ok ? STAT_GOOD : STAT_CHECK;
						state_q <= ST_STATUS;
					end
				end
				ST_STATUS:
					state_q <= ST_IDLE;
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			done <= 1'b0;
			status <= STAT_GOOD;
			sense_key <= 4'h0;
			sense_asc <= 8'h00;
			sense_ascq <= 8'h00;
		end
		else
		begin
			done <= (state_q == ST_STATUS);
			if (state_q == ST_STATUS)
			begin
				status <= status_q;
				sense_key <= bad_q ? SK_ILLEGAL : 4'h0;
				sense_asc <= bad_q ? ASC_INV_CDB : 8'h00;
				sense_ascq <= ASCQ_NONE;
			end
		end
	end
endmodule
`default_nettype wire

// file: verification/host_model.sv
/* Host data side: takes return bytes, sends delivery bytes.
   Assumes the bench pulses load with a byte count before each command. */
`timescale 1ns/1ps
`default_nettype none
module host_model
	import secproto_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic rst, // Async reset
	input wire logic slow, // Stall return bytes every other cycle
	input wire logic load, // New command
	input wire logic [31:0] send_n, // Bytes to send
	input wire logic [7:0] din_data, // Device byte
	input wire logic din_valid, // Device byte valid
	output logic din_ready, // Host takes byte
	input wire logic dout_ready, // Device takes byte
	output logic dout_valid, // Host byte valid
	output logic [7:0] dout_data, // Host byte
	output logic [31:0] rx_n, // Bytes received
	output logic [31:0] rx_nz // Nonzero bytes received
);
	logic [31:0] sent_q;
	logic [31:0] n_q;
	logic tick_q;
	assign din_ready = ~slow | tick_q;
	assign dout_valid = sent_q != n_q;
	// Pads from byte 3 on; idle line shows inverse of data
	assign dout_data = dout_valid ? (sent_q >= 32'h3 ? PAD_BYTE : 8'h5A) : 8'hA5;
	always_ff @(posedge clk or posedge rst)
		if (rst)
			tick_q <= 1'b0;
		else
			tick_q <= ~tick_q;
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			sent_q <= '0;
			n_q <= '0;
		end
		else if (load)
		begin
			sent_q <= '0;
			n_q <= send_n;
		end
		else if (dout_valid && dout_ready)
			sent_q <= sent_q + 32'h1;
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			rx_n <= '0;
			rx_nz <= '0;
		end
		else if (load)
		begin
			rx_n <= '0;
			rx_nz <= '0;
		end
		else if (din_valid && din_ready)
		begin
			rx_n <= rx_n + 32'h1;
			rx_nz <= rx_nz + {31'h0, din_data != 8'h00};
		end
endmodule
`default_nettype wire

// file: verification/sec_checker.sv
/* Port checker for the security command decoder.
   Assumes descriptors arrive whole, one command at a time. */
`timescale 1ns/1ps
`default_nettype none
module sec_checker
	import secproto_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic rst, // Async reset
	input wire logic cdb_valid, // Descriptor strobe
	input wire logic [7:0] cdb_byte, // Descriptor byte
	input wire logic [7:0] dout_data, // Host byte
	input wire logic dout_valid, // Host valid
	input wire logic dout_ready, // Device takes
	input wire logic din_valid, // Device valid
	input wire logic [7:0] eng_prot, // Engine selector
	input wire logic [15:0] eng_spec, // Engine specific
	input wire logic eng_start, // Engine start
	input wire logic [7:0] eng_data, // Engine byte
	input wire logic eng_data_valid, // Engine strobe
	input wire logic eng_style_b, // Wait style
	input wire logic done, // Complete
	input wire logic [7:0] status, // Status
	input wire logic [3:0] sense_key, // Sense key
	input wire logic [7:0] sense_asc // Sense code
);
	logic [3:0] n_q;
	logic [7:0] op_q;
	logic [7:0] pr_q;
	logic [15:0] sp_q;
	logic busy_q;
	logic last;
	logic ret_ok;
	logic del_ok;
	logic bad;
	assign last = cdb_valid && n_q == 4'hB;
	assign ret_ok = op_q == OP_SEC_IN && pr_q <= PROT_LAST;
	assign del_ok = op_q == OP_SEC_OUT && pr_q >= PROT_FIRST && pr_q <= PROT_LAST;
	assign bad = !ret_ok && !del_ok;
	always_ff @(posedge clk or posedge rst)
		if (rst)
			n_q <= 4'h0;
		else if (cdb_valid)
			n_q <= last ? 4'h0 : n_q + 4'h1;
	always_ff @(posedge clk)
		if (cdb_valid)
		begin
			if (n_q == 4'h0)
				op_q <= cdb_byte;
			if (n_q == 4'h1)
				pr_q <= cdb_byte;
			if (n_q == 4'h2)
				sp_q[15:8] <= cdb_byte;
			if (n_q == 4'h3)
				sp_q[7:0] <= cdb_byte;
		end
	always_ff @(posedge clk or posedge rst)
		if (rst)
			busy_q <= 1'b0;
		else if (last)
			busy_q <= 1'b1;
		else if (done)
			busy_q <= 1'b0;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	a_bad_check: assert property (done && bad |-> status == STAT_CHECK && sense_key == SK_ILLEGAL)
		else $error("refusal status wrong");
	a_bad_sense: assert property (done && bad |-> sense_asc == ASC_INV_CDB)
		else $error("refusal sense wrong");
	a_no_phase: assert property (busy_q && bad |-> !din_valid && !dout_ready)
		else $error("data phase on refused command");
	a_start_lat: assert property (last && !bad |-> ##[2:3] eng_start)
		else $error("engine start missing");
	a_spec_pass: assert property (eng_start |=> eng_spec == sp_q && eng_prot == pr_q)
		else $error("specific bytes not passed");
	a_dir_in: assert property (busy_q && op_q == OP_SEC_IN |-> !dout_ready)
		else $error("return takes host bytes");
	a_dir_out: assert property (busy_q && op_q == OP_SEC_OUT |-> !din_valid)
		else $error("delivery sends bytes");
	a_eng_copy: assert property (dout_valid && dout_ready |=> eng_data_valid && eng_data == $past(dout_data))
		else $error("delivered byte lost");
	a_ret_good: assert property (done && ret_ok |-> status == STAT_GOOD)
		else $error("return not good");
	a_del_good: assert property (done && del_ok && !eng_style_b |-> status == STAT_GOOD)
		else $error("delivery not good");
	c_ret: cover property (done && ret_ok);
	c_del: cover property (done && del_ok);
	c_bad: cover property (done && bad);
endmodule
bind secproto_cmd_decoder sec_checker u_chk (.clk(clk), .rst(rst), .cdb_valid(cdb_valid), .cdb_byte(cdb_byte),
	.dout_data(dout_data), .dout_valid(dout_valid), .dout_ready(dout_ready), .din_valid(din_valid),
	.eng_prot(eng_prot), .eng_spec(eng_spec), .eng_start(eng_start), .eng_data(eng_data),
	.eng_data_valid(eng_data_valid), .eng_style_b(eng_style_b), .done(done), .status(status),
	.sense_key(sense_key), .sense_asc(sense_asc));
`default_nettype wire

// file: verification/tb.sv
/* Self-checking bench for the security command decoder.
   Assumes host_model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module tb
	import secproto_pkg::*;
;
	typedef struct {logic [7:0] op; logic [7:0] pr; logic u; logic [31:0] len; logic [31:0] n;
		logic [7:0] st; logic [31:0] cnt;} row_s;
	logic clk, rst, cdb_valid, lu_reset, dout_valid, dout_ready, din_valid, din_ready, eng_start;
	logic eng_data_valid, eng_style_b, eng_done, eng_ok, res_valid, done, load, slow, nexus_loss, info_ready;
	logic [7:0] cdb_byte, cmd_nexus, dout_data, din_data, eng_prot, eng_data, res_data, status, sense_asc;
	logic [7:0] loss_nexus, sense_ascq;
	logic [15:0] eng_spec;
	logic [3:0] sense_key;
	logic [31:0] send_n, rx_n, rx_nz;
	int num_errors, tests_run, cyc, eng_n, info_n, t_done, t_eng, i;
	row_s rows [12] = '{
		'{OP_SEC_IN, 8'h00, 1'b0, 5, 0, STAT_GOOD, 5}, '{OP_SEC_IN, 8'h01, 1'b0, 3, 0, STAT_GOOD, 3},
		'{OP_SEC_IN, 8'h06, 1'b1, 1, 0, STAT_GOOD, 512}, '{OP_SEC_IN, 8'h02, 1'b0, 0, 0, STAT_GOOD, 0},
		'{OP_SEC_IN, 8'h07, 1'b0, 3, 0, STAT_CHECK, 0}, '{OP_SEC_IN, 8'hFF, 1'b0, 3, 0, STAT_CHECK, 0},
		'{OP_SEC_OUT, 8'h00, 1'b0, 3, 0, STAT_CHECK, 0}, '{OP_SEC_OUT, 8'h01, 1'b0, 4, 4, STAT_GOOD, 4},
		'{OP_SEC_OUT, 8'h06, 1'b1, 1, 512, STAT_GOOD, 512}, '{OP_SEC_OUT, 8'h07, 1'b0, 3, 0, STAT_CHECK, 0},
		'{OP_SEC_OUT, 8'hFF, 1'b0, 3, 0, STAT_CHECK, 0}, '{8'h12, 8'h01, 1'b0, 3, 0, STAT_CHECK, 0}};
	secproto_cmd_decoder dut (.clk(clk), .rst(rst), .cdb_valid(cdb_valid), .cdb_byte(cdb_byte),
		.cmd_nexus(cmd_nexus), .lu_reset(lu_reset), .nexus_loss(nexus_loss), .loss_nexus(loss_nexus),
		.dout_data(dout_data), .dout_valid(dout_valid), .dout_ready(dout_ready), .din_data(din_data),
		.din_valid(din_valid), .din_ready(din_ready), .eng_prot(eng_prot), .eng_spec(eng_spec),
		.eng_start(eng_start), .eng_data(eng_data), .eng_data_valid(eng_data_valid),
		.eng_style_b(eng_style_b), .eng_done(eng_done), .eng_ok(eng_ok), .info_data(8'h3C),
		.info_valid(1'b1), .info_ready(info_ready), .res_data(res_data), .res_valid(res_valid), .done(done),
		.status(status), .sense_key(sense_key), .sense_asc(sense_asc), .sense_ascq(sense_ascq));
	host_model host (.clk(clk), .rst(rst), .slow(slow), .load(load), .send_n(send_n), .din_data(din_data),
		.din_valid(din_valid), .din_ready(din_ready), .dout_ready(dout_ready), .dout_valid(dout_valid),
		.dout_data(dout_data), .rx_n(rx_n), .rx_nz(rx_nz));
	always #5 clk = ~clk;
	task automatic wrap_up();
		if (num_errors == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic err(input string m);
		num_errors++;
		$display("ERROR %0t %s", $time, m);
	endtask
	task automatic chk_st(input logic [7:0] st, input logic [3:0] key);
		tests_run++;
		if (status !== st || sense_key !== key || sense_ascq !== ASCQ_NONE)
			err("status mismatch");
		else if (sense_asc !== ((key == SK_ILLEGAL) ? ASC_INV_CDB : 8'h00))
			err("sense mismatch");
	endtask
	task automatic chk_n(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
			err("count mismatch");
	endtask
	task automatic cmd(input logic [7:0] op, input logic [7:0] pr, input logic u, input logic [31:0] len,
		input logic [31:0] n);
		logic [7:0] b [12];
		int k;
		b = '{op, pr, 8'h12, 8'h34, {u, 7'h00}, 8'h00, len[31:24], len[23:16], len[15:8], len[7:0], 8'h00, 8'h00};
		send_n <= n;
		load <= 1'b1;
		@(posedge clk);
		load <= 1'b0;
		for (k = 0; k < 12; k++)
		begin
			cdb_valid <= 1'b1;
			cdb_byte <= b[k];
			@(posedge clk);
		end
		cdb_valid <= 1'b0;
		k = 0;
		while (done !== 1'b1 && k < 3000)
		begin
			@(negedge clk);
			k++;
		end
		t_done = cyc;
		if (k == 3000)
			err("no completion");
		@(posedge clk);
	endtask
	task automatic push(input logic [7:0] d);
		res_data <= d;
		res_valid <= 1'b1;
		@(posedge clk);
		res_valid <= 1'b0;
		@(posedge clk);
	endtask
	always @(posedge clk)
	begin
		cyc++;
		eng_n = load ? 0 : eng_n + (eng_data_valid === 1'b1);
		info_n = load ? 0 : info_n + (info_ready === 1'b1);
		if (cyc == 40000)
		begin
			num_errors++;
			wrap_up();
		end
	end
	initial
	begin
		{clk, cdb_valid, lu_reset, eng_style_b, eng_done, eng_ok, res_valid, load, slow, nexus_loss} = '0;
		{cdb_byte, cmd_nexus, res_data, send_n, loss_nexus} = '0;
		rst = 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		for (i = 0; i < 12; i++)
		begin
			slow <= i[0];
			cmd(rows[i].op, rows[i].pr, rows[i].u, rows[i].len, rows[i].n);
			chk_st(rows[i].st, (rows[i].st == STAT_CHECK) ? SK_ILLEGAL : 4'h0);
			chk_n(rows[i].op == OP_SEC_IN ? rx_n : eng_n, rows[i].cnt);
			if (rows[i].op == OP_SEC_IN)
				chk_n(info_n, (rows[i].pr == PROT_INFO) ? rows[i].cnt : 0);
			if (rows[i].st == STAT_GOOD)
				chk_n({eng_prot, eng_spec}, {rows[i].pr, 16'h1234});
		end
		eng_style_b <= 1'b1;
		for (i = 0; i < 2; i++)
		begin
			fork
				cmd(OP_SEC_OUT, 8'h02, 1'b0, 2, 2);
				begin
					repeat (60) @(posedge clk);
					t_eng = cyc;
					eng_done <= 1'b1;
					eng_ok <= i[0];
					@(posedge clk);
					eng_done <= 1'b0;
				end
			join
			chk_n(t_done > t_eng, 1);
			chk_st(i[0] ? STAT_GOOD : STAT_CHECK, 4'h0);
		end
		eng_style_b <= 1'b0;
		cmd_nexus <= 8'h03;
		cmd(OP_SEC_OUT, 8'h01, 1'b0, 2, 2);
		push(8'h77);
		push(8'h88);
		cmd_nexus <= 8'h04;
		cmd(OP_SEC_IN, 8'h01, 1'b0, 2, 0);
		chk_n(rx_nz, 0);
		cmd_nexus <= 8'h03;
		cmd(OP_SEC_IN, 8'h01, 1'b0, 2, 0);
		chk_n(rx_nz, 2);
		cmd(OP_SEC_IN, 8'h01, 1'b0, 2, 0);
		chk_n(rx_n, 2);
		chk_n(rx_nz, 0);
		cmd(OP_SEC_OUT, 8'h01, 1'b0, 2, 2);
		push(8'h77);
		lu_reset <= 1'b1;
		@(posedge clk);
		lu_reset <= 1'b0;
		cmd(OP_SEC_IN, 8'h01, 1'b0, 2, 0);
		chk_n(rx_nz, 0);
		cmd(OP_SEC_OUT, 8'h01, 1'b0, 2, 2);
		push(8'h77);
		loss_nexus <= 8'h04;
		nexus_loss <= 1'b1;
		@(posedge clk);
		nexus_loss <= 1'b0;
		cmd(OP_SEC_IN, 8'h01, 1'b0, 2, 0);
		chk_n(rx_nz, 1);
		chk_n(rx_n, 2);
		cmd(OP_SEC_OUT, 8'h01, 1'b0, 2, 2);
		push(8'h77);
		loss_nexus <= 8'h03;
		nexus_loss <= 1'b1;
		@(posedge clk);
		nexus_loss <= 1'b0;
		cmd(OP_SEC_IN, 8'h01, 1'b0, 2, 0);
		chk_n(rx_nz, 0);
		cmd_nexus <= 8'h00;
		cmd(OP_SEC_OUT, 8'h01, 1'b0, 2, 2);
		push(8'h77);
		cmd(OP_SEC_OUT, 8'h07, 1'b0, 2, 0);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		chk_st(STAT_GOOD, 4'h0);
		chk_n({31'h0, done}, 0);
		cmd(OP_SEC_IN, 8'h01, 1'b0, 2, 0);
		chk_n(rx_nz, 0);
		wrap_up();
	end
endmodule
`default_nettype wire
